// file: design/amp_pkg.sv
// Constants, state type and helpers for the registered macrocell array
package amp_pkg;
    // Array dimensions
    localparam int AMP_NMC = 12;
    localparam int AMP_NPAIR = 6;
    localparam int AMP_NDED = 13;
    localparam int AMP_NLIT = 31;
    localparam int AMP_NPT = 192;
    localparam int AMP_NDPT = 8;
    localparam int AMP_SOP_ALLOC [AMP_NMC] = '{4, 12, 6, 10, 8, 8, 8, 8, 10, 6, 12, 4};
    // Dedicated term slots inside one macrocell
    localparam int AMP_PT_ST_RST = 0;
    localparam int AMP_PT_ST_SET = 1;
    localparam int AMP_PT_ST_CLK = 2;
    localparam int AMP_PT_IN_RST = 3;
    localparam int AMP_PT_IN_SET = 4;
    localparam int AMP_PT_IN_CLK = 5;
    localparam int AMP_PT_OE = 6;
    localparam int AMP_PT_XOR = 7;
    // Literal positions and the global enable pin
    localparam int AMP_LIT_FB = 13;
    localparam int AMP_LIT_SH = 25;
    localparam int AMP_GOE_BIT = 12;
    localparam int AMP_TERM_EN_BIT = 31;
    // Register map (byte addresses)
    localparam int AMP_AW = 12;
    localparam logic [11:0] AMP_PT_END = 12'h600;
    localparam logic [11:0] AMP_ADDR_FFSTAT = 12'h800;
    localparam logic [11:0] AMP_ADDR_OESTAT = 12'h804;
    localparam logic [11:0] AMP_ADDR_CFGSTAT = 12'h808;
    localparam logic [1:0] AMP_RESP_OKAY = 2'h0;
    localparam logic [1:0] AMP_RESP_SLVERR = 2'h2;
    localparam logic [11:0] AMP_FF_RST = 12'h000;

    typedef struct packed {
        logic [12:0] ded1;
        logic [12:0] ded2;
        logic [11:0] io1;
        logic [11:0] io2;
        logic [11:0] oes1;
        logic [11:0] oes2;
        logic [11:0] fbs1;
        logic [11:0] fbs2;
        logic [5:0] shs1;
        logic [5:0] shs2;
        logic [11:0] st_q;
        logic [11:0] in_q;
        logic [11:0] stck_q;
        logic [11:0] inck_q;
        logic [11:0] oe_q;
        logic aw_ok;
        logic [11:0] aw_a;
        logic w_ok;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } amp_state_s;

    // First term index of a macrocell; each adjacent pair spans 32 terms
    function automatic int amp_term_base(input int mc);
        int b;
        b = 0;
        for (int k = 0; k < mc; k++) b += AMP_NDPT + AMP_SOP_ALLOC[k];
        return b;
    endfunction

    // Term mask area decode, shared by the read and write paths
    function automatic logic amp_is_pt(input logic [11:0] a);
        return a < AMP_PT_END;
    endfunction
endpackage

// file: design/amp_macrocells.sv
// Twelve registered I/O macrocells with a programmable product-term array
// Operation
// - Each macrocell has a state flip-flop from the array and an input flip-flop from its pin
// - Every flip-flop has its own reset, set and clock product terms
// - State data is one XOR term against an OR of several terms
// - Set alone forces one, reset alone forces zero, over the clock
// - Set and reset together make the flip-flop follow its data input
// - Feedback select picks state flip-flop when zero, input flip-flop when one
// - Enable select picks global enable when one, own enable term when zero
// - Shared pair input comes from upper input flip-flop, or lower when selected
// - Twelve enable selects, twelve feedback selects, six shared selects
// - Each pair owns 32 terms, eight dedicated per macrocell, sixteen summed
// - Summed terms per macrocell: 4,12,6,10,8,8,8,8,10,6,12,4
// - Array sees 13 pins, 12 feedbacks, 6 shared inputs, true and inverted
// - Flip-flop clocks are product terms, edges caused by input changes
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
module amp_macrocells (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Device pins
    input wire logic [amp_pkg::AMP_NDED-1:0] ded_in,
    input wire logic [amp_pkg::AMP_NMC-1:0] io_in,
    output logic [amp_pkg::AMP_NMC-1:0] io_out,
    output logic [amp_pkg::AMP_NMC-1:0] io_oe_n,
    // Static configuration
    input wire logic [amp_pkg::AMP_NMC-1:0] oe_source_select,
    input wire logic [amp_pkg::AMP_NMC-1:0] feedback_source_select,
    input wire logic [amp_pkg::AMP_NPAIR-1:0] shared_input_select,
    // AXI4-Lite slave
    input wire logic [amp_pkg::AMP_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [amp_pkg::AMP_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import amp_pkg::*;

    // Every check runs on the core clock and rests while reset is held
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Model notes
    // - Term clocks are sampled on core_clk; a term pulse shorter than one cycle is lost.
    // - Pins and selection bits reach the terms two cycles after they change.
    // - A flip-flop answers one cycle after its set, reset or clock term moves.
    // - Transparent mode (set and reset together) is registered, not a through path,
    //   so feedback never forms a combinational loop through the array.
    // - Set and reset act without a clock edge, but still one cycle late.
    // - A cleared term mask drives a zero term, so a fresh array holds every flop.
    // - The global enable is taken from dedicated pin 12, high meaning drive.
    // - Selection bits are meant to stay fixed; they are synchronised only so that
    //   a change cannot make the flops metastable, not so that it is glitch free.
    // - Status words are read-only and answer a write with an error response.
    // - Byte strobes are honoured on term words.
    // - Unmapped reads return zero with an error response.
    // - Only one write and one read may be in flight at a time.

    amp_state_s s;
    amp_state_s n;
    // Word 2t: bit 31 enables term t, bits 30:0 need the true literal
    // Word 2t+1: bits 30:0 need the inverted literal
    // A term asking for both forms of one literal can never be true
    logic [31:0] pt_mem [2*AMP_NPT];
    logic [AMP_NLIT-1:0] lits;
    logic [AMP_NMC-1:0] fb;
    logic [AMP_NPAIR-1:0] sh;
    logic [AMP_NPT-1:0] pt;
    logic [AMP_NMC-1:0] st_d, st_s, st_r, st_ck, in_s, in_r, in_ck, oe_pt;
    logic mem_we;

    // Next flip-flop value; set and reset act ahead of the clock edge
    function automatic logic ff_next(input logic q, input logic d, input logic st,
                                     input logic rs, input logic edg);
        if (st && rs) return d;
        if (st) return 1'b1;
        if (rs) return 1'b0;
        if (edg) return d;
        return q;
    endfunction

    // Feedback and shared inputs come from registered outputs, so no loop forms
    always_comb begin
        for (int i = 0; i < AMP_NMC; i++) begin
            fb[i] = s.fbs2[i] ? s.in_q[i] : s.st_q[i];
        end
        for (int p = 0; p < AMP_NPAIR; p++) begin
            sh[p] = s.shs2[p] ? s.in_q[2*p+1] : s.in_q[2*p];
        end
    end
    assign lits = {sh, fb, s.ded2};

    // A term is live only with its enable bit; a cleared array drives nothing
    genvar g;
    generate
        for (g = 0; g < AMP_NPT; g++) begin : g_pt
            assign pt[g] = pt_mem[2*g][AMP_TERM_EN_BIT]
                & (&(lits | ~pt_mem[2*g][AMP_NLIT-1:0]))
                & (&(~lits | ~pt_mem[2*g+1][AMP_NLIT-1:0]));
            chk_term_disabled: assert property (!pt_mem[2*g][AMP_TERM_EN_BIT] |-> !pt[g])
                else $error("disabled term is live");
        end
    endgenerate

    // Term layout of one macrocell, counted from its base:
    //   0 state reset, 1 state set, 2 state clock,
    //   3 input reset, 4 input set, 5 input clock,
    //   6 output enable, 7 polarity or toggle term,
    //   then its share of summed terms; two cells of a pair span 32 terms.
    // Per-macrocell slicing of the term array
    generate
        for (g = 0; g < AMP_NMC; g++) begin : g_mc
            localparam int B = amp_term_base(g);
            localparam int N = AMP_SOP_ALLOC[g];
            logic sop;
            assign sop = |pt[B+AMP_NDPT +: N];
            assign st_d[g] = pt[B+AMP_PT_XOR] ^ sop;
            assign st_r[g] = pt[B+AMP_PT_ST_RST];
            assign st_s[g] = pt[B+AMP_PT_ST_SET];
            assign st_ck[g] = pt[B+AMP_PT_ST_CLK];
            assign in_r[g] = pt[B+AMP_PT_IN_RST];
            assign in_s[g] = pt[B+AMP_PT_IN_SET];
            assign in_ck[g] = pt[B+AMP_PT_IN_CLK];
            assign oe_pt[g] = pt[B+AMP_PT_OE];

            chk_set_forces_one: assert property (st_s[g] && !st_r[g] |=> s.st_q[g])
                else $error("state set did not force one");
            chk_reset_forces_zero: assert property (st_r[g] && !st_s[g] |=> !s.st_q[g])
                else $error("state reset did not force zero");
            chk_bypass_follows_d: assert property (st_s[g] && st_r[g] |=> s.st_q[g] == $past(st_d[g]))
                else $error("bypass did not pass data");
            chk_xor_data_load: assert property (st_ck[g] && !s.stck_q[g] && !st_s[g] && !st_r[g]
                |=> s.st_q[g] == $past(pt[B+AMP_PT_XOR] ^ sop))
                else $error("state load is not the xor of terms");
            chk_state_holds: assert property (!(st_ck[g] && !s.stck_q[g]) && !st_s[g] && !st_r[g]
                |=> $stable(s.st_q[g]))
                else $error("state changed without a term clock edge");
            chk_input_ff_load: assert property (in_ck[g] && !s.inck_q[g] && !in_s[g] && !in_r[g]
                |=> s.in_q[g] == $past(s.io2[g]))
                else $error("input flip-flop missed its pin");
            chk_oe_source_pick: assert property (s.oes2[g] && !s.ded2[AMP_GOE_BIT]
                |=> io_oe_n[g])
                else $error("global enable low yet pin driven");
            chk_feedback_pick: assert property (s.fbs2[g] |-> lits[AMP_LIT_FB+g] == s.in_q[g])
                else $error("feedback ignores input flip-flop");

            // Input flip-flop obeys the same set and reset rules as the state one
            chk_in_set_one: assert property (in_s[g] && !in_r[g] |=> s.in_q[g])
                else $error("input set did not force one");
            chk_in_reset_zero: assert property (in_r[g] && !in_s[g] |=> !s.in_q[g])
                else $error("input reset did not force zero");
            chk_in_bypass: assert property (in_s[g] && in_r[g]
                |=> s.in_q[g] == $past(s.io2[g]))
                else $error("input bypass did not pass pin");
            chk_in_holds: assert property (!(in_ck[g] && !s.inck_q[g]) && !in_s[g] && !in_r[g]
                |=> $stable(s.in_q[g]))
                else $error("input changed without a term clock edge");
            // Without the select bit the pin follows the macrocell's own term
            chk_oe_term_pick: assert property (!s.oes2[g]
                |=> io_oe_n[g] == !$past(oe_pt[g]))
                else $error("enable ignores own term");
            chk_oe_global_on: assert property (s.oes2[g] && s.ded2[AMP_GOE_BIT]
                |=> !io_oe_n[g])
                else $error("global enable high yet pin released");
            chk_feedback_state: assert property (!s.fbs2[g]
                |-> lits[AMP_LIT_FB+g] == s.st_q[g])
                else $error("feedback ignores state flip-flop");
        end
    endgenerate

    // Each pair's shared literal follows its select bit
    generate
        for (g = 0; g < AMP_NPAIR; g++) begin : g_pair
            chk_shared_upper: assert property (!s.shs2[g] |-> sh[g] == s.in_q[2*g])
                else $error("shared input not from upper cell");
            chk_shared_lower: assert property (s.shs2[g] |-> sh[g] == s.in_q[2*g+1])
                else $error("shared input not from lower cell");
            chk_shared_literal: assert property (lits[AMP_LIT_SH+g] == sh[g])
                else $error("shared literal misplaced");
        end
    endgenerate

    // Event-driven flip-flops; clock terms are edge-detected on the core clock
    always_comb begin
        n = s;
        // Pins and configuration pass two flip-flops each
        n.ded1 = ded_in;
        n.ded2 = s.ded1;
        n.io1 = io_in;
        n.io2 = s.io1;
        n.oes1 = oe_source_select;
        n.oes2 = s.oes1;
        n.fbs1 = feedback_source_select;
        n.fbs2 = s.fbs1;
        n.shs1 = shared_input_select;
        n.shs2 = s.shs1;
        n.stck_q = st_ck;
        n.inck_q = in_ck;
        for (int i = 0; i < AMP_NMC; i++) begin
            n.st_q[i] = ff_next(s.st_q[i], st_d[i], st_s[i], st_r[i],
                                st_ck[i] & ~s.stck_q[i]);
            n.in_q[i] = ff_next(s.in_q[i], s.io2[i], in_s[i], in_r[i],
                                in_ck[i] & ~s.inck_q[i]);
            n.oe_q[i] = s.oes2[i] ? s.ded2[AMP_GOE_BIT] : oe_pt[i];
        end
        // Bus timing: ready is high whenever no item is held; the answer follows
        // one cycle after both halves of a write are held, or after the read address
        // Write address and data latch independently, in either order
        if (s_axi_awvalid && !s.aw_ok) begin
            n.aw_ok = 1'b1;
            n.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s.w_ok) begin
            n.w_ok = 1'b1;
            n.w_d = s_axi_wdata;
            n.w_s = s_axi_wstrb;
        end
        if (mem_we || (s.aw_ok && s.w_ok && !s.bvalid)) begin
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = amp_is_pt(s.aw_a) ? AMP_RESP_OKAY : AMP_RESP_SLVERR;
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        // Reads answer one cycle after the address is taken
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s.rvalid) begin
            n.rvalid = 1'b1;
            n.rresp = AMP_RESP_OKAY;
            if (amp_is_pt(s_axi_araddr)) begin
                n.rdata = pt_mem[s_axi_araddr[10:2]];
            end else if (s_axi_araddr == AMP_ADDR_FFSTAT) begin
                n.rdata = {4'h0, s.in_q, 4'h0, s.st_q};
            end else if (s_axi_araddr == AMP_ADDR_OESTAT) begin
                n.rdata = {20'h00000, s.oe_q};
            end else if (s_axi_araddr == AMP_ADDR_CFGSTAT) begin
                n.rdata = {2'h0, s.shs2, s.fbs2, s.oes2};
            end else begin
                n.rdata = 32'h00000000;
                n.rresp = AMP_RESP_SLVERR;
            end
        end
    end

    // Only the term area is writable; status words answer with an error
    assign mem_we = s.aw_ok && s.w_ok && !s.bvalid && amp_is_pt(s.aw_a);

    // State register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s <= '0;
            s.st_q <= AMP_FF_RST;
            s.in_q <= AMP_FF_RST;
        end else begin
            s <= n;
        end
    end

    // Term masks clear at reset so that every term starts disabled
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int k = 0; k < 2*AMP_NPT; k++) pt_mem[k] <= 32'h00000000;
        end else if (mem_we) begin
            for (int b = 0; b < 4; b++) begin
                if (s.w_s[b]) pt_mem[s.aw_a[10:2]][8*b +: 8] <= s.w_d[8*b +: 8];
            end
        end
    end

    // Outputs
    assign io_out = s.st_q;
    assign io_oe_n = ~s.oe_q;
    assign s_axi_awready = !s.aw_ok;
    assign s_axi_wready = !s.w_ok;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;

    // Bus checks and one shared-input check
    chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    chk_shared_from_lower: assert property (s.shs2[0] |-> lits[AMP_LIT_SH] == s.in_q[1])
        else $error("shared input not from lower cell");
    chk_read_unmapped: assert property (s_axi_arvalid && s_axi_arready
        && !amp_is_pt(s_axi_araddr) && s_axi_araddr > AMP_ADDR_CFGSTAT
        |=> s_axi_rvalid && s_axi_rresp == AMP_RESP_SLVERR)
        else $error("unmapped read not refused");

    // Read channel
    chk_rvalid_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped early");
    chk_read_one_cycle: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("read data changed while waiting");
    chk_arready_low: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while busy");
    chk_read_okay_terms: assert property (s_axi_arvalid && s_axi_arready
        && amp_is_pt(s_axi_araddr) |=> s_axi_rresp == AMP_RESP_OKAY)
        else $error("term read refused");

    // Write channel
    chk_bresp_stable: assert property (s_axi_bvalid && !s_axi_bready |=> $stable(s_axi_bresp))
        else $error("write response changed while waiting");
    chk_write_answer: assert property (s.aw_ok && s.w_ok && !s_axi_bvalid |=> s_axi_bvalid)
        else $error("write answer late");
    chk_awready_low: assert property (s.aw_ok |-> !s_axi_awready)
        else $error("second write address accepted");
    chk_wready_low: assert property (s.w_ok |-> !s_axi_wready)
        else $error("second write data accepted");
    chk_no_write_busy: assert property (s_axi_bvalid |-> !mem_we)
        else $error("write landed while response pending");
    // Refused writes leave every term untouched
    chk_refused_write: assert property (s.aw_ok && s.w_ok && !amp_is_pt(s.aw_a) |-> !mem_we)
        else $error("refused write reached the terms");

    cov_bypass: cover property (st_s[0] && st_r[0] ##1 s.st_q[0]);
    cov_clock_load: cover property (st_ck[1] && !s.stck_q[1] ##1 s.st_q[1]);
    cov_write_done: cover property (mem_we ##1 s_axi_bvalid && s_axi_bready);
    cov_refused_read: cover property (s_axi_rvalid && s_axi_rresp == AMP_RESP_SLVERR);
    cov_input_bypass: cover property (in_s[0] && in_r[0] ##1 s.in_q[0]);
endmodule // amp_macrocells

// file: test/amp_pin_model.sv
// Outside logic sharing the twelve I/O pins with the macrocells
`timescale 1ns/1ps
module amp_pin_model (
    // Pin levels
    input wire logic [11:0] io_out,
    input wire logic [11:0] io_oe_n,
    input wire logic [11:0] ext_val,
    output logic [11:0] io_in
);
    // Device wins where it drives, so the outside value only shows on released pins
    always_comb begin
        for (int k = 0; k < 12; k++) io_in[k] = io_oe_n[k] ? ext_val[k] : io_out[k];
    end
endmodule // amp_pin_model

// file: test/async_registered_macrocell_pair_test.sv
// Self-checking bench for the registered macrocell array
`timescale 1ns/1ps
module async_registered_macrocell_pair_test;
    import amp_pkg::*;
    localparam logic [31:0] EN = 32'h8000_0000;
    logic core_clk, rst_n, awvalid, wvalid, arvalid;
    logic [12:0] ded_in, d;
    logic [11:0] ext_val, io_in, io_out, io_oe_n, oe_sel, fb_sel, v, awaddr, araddr;
    logic [5:0] sh_sel;
    logic [31:0] wdata;
    int seed = 29;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;
    int b, m;
    logic aw_rdy, w_rdy, ar_rdy, bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;

    // Strobes and response readies stay high; the slave paces every transfer
    amp_macrocells u_amp_macrocells (.core_clk(core_clk), .rst_n(rst_n), .ded_in(ded_in),
        .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .oe_source_select(oe_sel),
        .feedback_source_select(fb_sel), .shared_input_select(sh_sel),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(aw_rdy),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(w_rdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(ar_rdy),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
    amp_pin_model u_amp_pin_model (.io_out(io_out), .io_oe_n(io_oe_n), .ext_val(ext_val),
        .io_in(io_in));

    // Clock and a watchdog against hangs
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, s);
        end
    endtask

    // Write; each channel drops valid at the edge where it is taken
    task automatic wr(input logic [11:0] a, input logic [31:0] dt, input logic [1:0] er);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= dt;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awvalid && aw_rdy) awvalid <= 1'b0;
            if (wvalid && w_rdy) wvalid <= 1'b0;
        end while (!bvalid);
        chk(32'(bresp), 32'(er), "write response");
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] msk,
                       input logic [1:0] er);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arvalid && ar_rdy) arvalid <= 1'b0;
        end while (!rvalid);
        chk(rdata & msk, e, "read data");
        chk(32'(rresp), 32'(er), "read response");
    endtask

    // Term t lives at byte 8t: enable bit plus true-literal mask
    task automatic tw(input int t, input logic [31:0] dt);
        wr(12'(t * 8), dt, AMP_RESP_OKAY);
    endtask

    // First term of a macrocell: eight dedicated terms plus its summed share before it
    function automatic int tbase(input int mc);
        tbase = 0;
        for (int k = 0; k < mc; k++) tbase += 8 + AMP_SOP_ALLOC[k];
    endfunction

    function automatic logic [11:0] oe_n_exp(input logic [12:0] dd);
        for (int k = 0; k < 12; k++) oe_n_exp[k] = !(oe_sel[k] ? dd[12] : dd[2]);
    endfunction

    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        ded_in = '0;
        ext_val = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        oe_sel = 12'($random(seed));
        fb_sel = 12'($random(seed));
        sh_sel = 6'($random(seed));
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        // Reset state, selection read-back and refused addresses
        chk({20'h0, io_out}, 32'h0, "state after reset");
        chk({20'h0, io_oe_n}, 32'hFFF, "enables after reset");
        rdc(AMP_ADDR_CFGSTAT, {2'h0, sh_sel, fb_sel, oe_sel}, '1, AMP_RESP_OKAY);
        rdc(12'hFFC, 32'h0, '1, AMP_RESP_SLVERR);
        wr(12'h900, 32'hFFFF_FFFF, AMP_RESP_SLVERR);
        $display("test reset_and_map done");
        // Set, hold and reset on every cell; a wrong term base hits another cell
        for (int i = 0; i < 12; i++) begin
            b = tbase(i);
            tw(b + AMP_PT_ST_SET, EN);
            repeat (4) @(posedge core_clk);
            chk({20'h0, io_out}, 32'(1 << i), "set forces one");
            tw(b + AMP_PT_ST_SET, 32'h0);
            repeat (4) @(posedge core_clk);
            chk(32'(io_out[i]), 32'h1, "holds with no clock term");
            tw(b + AMP_PT_ST_RST, EN);
            repeat (4) @(posedge core_clk);
            chk({20'h0, io_out}, 32'h0, "reset forces zero");
            tw(b + AMP_PT_ST_RST, 32'h0);
        end
        $display("test set_reset done");
        // One random cell made transparent on XOR data; all enables from terms or pin
        m = ($random(seed) & 32'h7FFF_FFFF) % 10;
        b = tbase(m);
        tw(b + AMP_PT_ST_SET, EN);
        tw(b + AMP_PT_ST_RST, EN);
        tw(b + AMP_PT_XOR, EN | 32'h1);
        tw(b + AMP_NDPT, EN | 32'h2);
        for (int k = 0; k < 12; k++) tw(tbase(k) + AMP_PT_OE, EN | 32'h4);
        for (int i = 0; i < 10; i++) begin
            d = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1FFF : 13'($random(seed));
            ded_in <= d;
            repeat (5) @(posedge core_clk);
            chk(32'(io_out[m]), 32'(d[0] ^ d[1]), "xor data path");
            chk({20'h0, io_oe_n}, {20'h0, oe_n_exp(d)}, "enable source");
        end
        rdc(AMP_ADDR_OESTAT, {20'h0, ~oe_n_exp(d)}, '1, AMP_RESP_OKAY);
        $display("test transparent_and_enable done");
        // Pins through transparent input flops, then shared and feedback literals
        for (int k = 0; k < 12; k++) begin
            tw(tbase(k) + AMP_PT_IN_SET, EN);
            tw(tbase(k) + AMP_PT_IN_RST, EN);
        end
        ded_in <= '0;
        b = tbase(11);
        tw(b + AMP_PT_ST_SET, EN | 32'(1 << AMP_LIT_SH));
        tw(b + AMP_PT_ST_RST, EN);
        wr(12'((b + AMP_PT_ST_RST) * 8 + 4), 32'(1 << AMP_LIT_SH), AMP_RESP_OKAY);
        b = tbase(10);
        tw(b + AMP_PT_ST_SET, EN | 32'(1 << (AMP_LIT_FB + 11)));
        tw(b + AMP_PT_ST_RST, EN);
        wr(12'((b + AMP_PT_ST_RST) * 8 + 4), 32'(1 << (AMP_LIT_FB + 11)), AMP_RESP_OKAY);
        for (int i = 0; i < 10; i++) begin
            v = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($random(seed));
            ext_val <= v;
            repeat (8) @(posedge core_clk);
            rdc(AMP_ADDR_FFSTAT, {4'h0, v, 16'h0}, 32'h0FFF_0000, AMP_RESP_OKAY);
            chk(32'(io_out[11]), 32'(sh_sel[0] ? v[1] : v[0]), "shared input");
            chk(32'(io_out[10]), 32'(fb_sel[11] ? v[11] : (sh_sel[0] ? v[1] : v[0])),
                "feedback source");
        end
        $display("test input_paths done");
        complete_run();
    end
endmodule // async_registered_macrocell_pair_test
